// ### spi_cfg.sv
// Purpose: byte-wide serial peripheral interface, master or slave, AXI4-Lite registers
// Assumes: sys_clk 10 MHz, synchronous active-high rst, pins asynchronous
// Notes: slave mode samples pins through three flip-flops, so slave clock must be slow
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
module spi_cfg (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   wait_mode,
	input  wire logic                   sck_in,
	input  wire logic                   mosi_in,
	input  wire logic                   miso_in,
	input  wire logic                   ss_n_in,
	output spi_cfg_pkg::pins_out_t      pins_out,
	output spi_cfg_pkg::pins_oe_t       pins_oe,
	output logic                        irq
);
	import spi_cfg_pkg::*;

	// ==========================================================
	// register bus
	logic [7:0]  ctrl1_r, ctrl2_r, rate_r;
	logic [7:0]  aw_addr_r, rx_buf_r, tx_buf_r;
	logic [7:0]  wbyte_r;
	logic        aw_have_r, w_have_r, w_lane_r;
	logic        bvalid_r, rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  bresp_r, rresp_r;
	logic        rxf_r, txe_r, mode_fault_flag_r, mode_fault_flag_armed_r;

	wire do_write = aw_have_r && w_have_r && !bvalid_r;
	wire do_read  = s_axi_arvalid && !rvalid_r;
	wire wr_c1    = do_write && aw_addr_r == OFS_CTRL1 && w_lane_r;
	wire wr_c2    = do_write && aw_addr_r == OFS_CTRL2 && w_lane_r;
	wire wr_br    = do_write && aw_addr_r == OFS_RATE && w_lane_r;
	wire wr_dat   = do_write && aw_addr_r == OFS_DATA && w_lane_r;
	wire rd_flag  = do_read && s_axi_araddr == OFS_FLAGS;
	wire rd_dat   = do_read && s_axi_araddr == OFS_DATA;

	function automatic logic known(input logic [7:0] a);
		known = a == OFS_CTRL1 || a == OFS_CTRL2 || a == OFS_RATE ||
			a == OFS_FLAGS || a == OFS_DATA;
	endfunction : known

	wire [7:0] flags = {rxf_r, 1'b0, txe_r, mode_fault_flag_r, 4'h0};
	logic [7:0] rsel;
	always_comb begin
		case (s_axi_araddr)
			OFS_CTRL1: rsel = ctrl1_r;
			OFS_CTRL2: rsel = ctrl2_r;
			OFS_RATE:  rsel = rate_r;
			OFS_FLAGS: rsel = flags;
			OFS_DATA:  rsel = rx_buf_r;
			default:   rsel = 8'h00;
		endcase
	end

	assign s_axi_awready = !aw_have_r;
	assign s_axi_wready  = !w_have_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// ==========================================================
	// configuration fields
	wire en      = ctrl1_r[B_EN];
	wire master  = ctrl1_r[B_MST];
	wire clock_polarity    = ctrl1_r[B_POL];
	wire clock_phase    = ctrl1_r[B_PHA];
	wire lsb     = ctrl1_r[B_LSB];
	wire fen     = ctrl2_r[B_FEN];
	wire bidir   = ctrl2_r[B_SINGLE_WIRE_SELECT];
	wire halted  = wait_mode && ctrl2_r[B_SWAI];
	wire ss_fault_in = master && fen && !ctrl1_r[B_SELECT_OUTPUT_ENABLE];
	wire ss_drive    = master && fen && ctrl1_r[B_SELECT_OUTPUT_ENABLE];

	// ==========================================================
	// pin synchronisers (change taken when stages two and three agree)
	logic [2:0] s_sck, s_mosi, s_miso, s_ss;
	logic       f_sck_r, f_mosi_r, f_miso_r, f_ss_r;
	always_ff @(posedge sys_clk) begin
		s_sck  <= {s_sck[1:0], sck_in};
		s_mosi <= {s_mosi[1:0], mosi_in};
		s_miso <= {s_miso[1:0], miso_in};
		s_ss   <= {s_ss[1:0], ss_n_in};
		if (s_sck[2] == s_sck[1])
			f_sck_r <= s_sck[2];
		if (s_mosi[2] == s_mosi[1])
			f_mosi_r <= s_mosi[2];
		if (s_miso[2] == s_miso[1])
			f_miso_r <= s_miso[2];
		if (s_ss[2] == s_ss[1])
			f_ss_r <= s_ss[2];
	end

	// ==========================================================
	// master rate: prescale 1..8, then divide 2,4,..,256
	logic [2:0] pre_cnt_r;
	logic [7:0] div_cnt_r;
	wire  [2:0] pre_sel = rate_r[6:4];
	wire  [2:0] div_sel = rate_r[2:0];
	wire  pre_tick = pre_cnt_r == pre_sel;
	wire  [7:0] half_lim = 8'((8'h01 << div_sel) - 8'h01);
	wire  half_tick = pre_tick && div_cnt_r == half_lim;

	// ==========================================================
	// transfer engine
	typedef enum logic [1:0] {IDLE, LEAD, RUN, TAIL} st_t;
	st_t        st_r;
	logic [7:0] shf_r;
	logic [4:0] edg_r;
	logic       sck_r, out_bit_r, ss_r, last_sck_r, last_ss_r;
	wire  in_bit = master ? (bidir ? f_mosi_r : f_miso_r) : f_mosi_r;
	wire  [7:0] sh_in  = lsb ? {in_bit, shf_r[7:1]} : {shf_r[6:0], in_bit};
	wire  first_bit    = lsb ? tx_buf_r[0] : tx_buf_r[7];
	// the shifter has already moved by one sample, so the next bit sits at the end
	wire  next_bit     = lsb ? shf_r[0] : shf_r[7];
	// slave edges seen on filtered pins
	wire  s_edge  = f_sck_r != last_sck_r;
	wire  s_lead  = s_edge && (f_sck_r != clock_polarity);
	wire  s_sel   = !f_ss_r;
	wire  s_start = last_ss_r && !f_ss_r;
	wire  sample_edge = clock_phase ? !s_lead : s_lead;

	always_ff @(posedge sys_clk) begin
		last_sck_r <= f_sck_r;
		last_ss_r  <= f_ss_r;
		if (rst) begin
			ctrl1_r <= CTRL1_RST;
			ctrl2_r <= CTRL2_RST;
			rate_r <= RATE_RST;
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			bvalid_r <= 1'b0;
			rvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			aw_addr_r <= 8'h00;
			wbyte_r <= 8'h00;
			w_lane_r <= 1'b0;
			rx_buf_r <= 8'h00;
			tx_buf_r <= 8'h00;
			rxf_r <= 1'b0;
			txe_r <= 1'b1;
			mode_fault_flag_r <= 1'b0;
			mode_fault_flag_armed_r <= 1'b0;
			st_r <= IDLE;
			shf_r <= 8'h00;
			edg_r <= 5'd0;
			sck_r <= 1'b0;
			out_bit_r <= 1'b0;
			ss_r <= 1'b1;
			pre_cnt_r <= 3'd0;
			div_cnt_r <= 8'h00;
		end else begin
			if (s_axi_awvalid && !aw_have_r) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && !w_have_r) begin
				w_have_r <= 1'b1;
				wbyte_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= known(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready)
				bvalid_r <= 1'b0;
			if (do_read) begin
				rvalid_r <= 1'b1;
				rdata_r <= {24'h0, rsel};
				rresp_r <= known({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready)
				rvalid_r <= 1'b0;
			if (wr_c1)
				ctrl1_r <= wbyte_r & CTRL1_MSK;
			if (wr_c2)
				ctrl2_r <= wbyte_r & CTRL2_MSK;
			if (wr_br)
				rate_r <= wbyte_r & RATE_MSK;
			if (rd_flag && mode_fault_flag_r)
				mode_fault_flag_armed_r <= 1'b1;
			if (wr_c1 && mode_fault_flag_armed_r) begin
				mode_fault_flag_r <= 1'b0;
				mode_fault_flag_armed_r <= 1'b0;
			end
			if (rd_dat)
				rxf_r <= 1'b0;
			if (wr_dat) begin
				tx_buf_r <= wbyte_r;
				txe_r <= 1'b0;
			end
			// fault: set wins over a clearing write in the same cycle
			if (en && ss_fault_in && !f_ss_r) begin
				mode_fault_flag_r <= 1'b1;
				mode_fault_flag_armed_r <= 1'b0;
				ctrl1_r[B_MST] <= 1'b0;
				st_r <= IDLE;
			end else if (!en) begin
				st_r <= IDLE;
				ss_r <= 1'b1;
				sck_r <= 1'b0;
			end else if (!halted) begin
				if (master) begin
					pre_cnt_r <= pre_tick ? 3'd0 : 3'(pre_cnt_r + 3'd1);
					if (pre_tick)
						div_cnt_r <= half_tick ? 8'h00 : 8'(div_cnt_r + 8'h01);
				end
				case (st_r)
					IDLE: begin
						sck_r <= 1'b0;
						if (master && !txe_r && !wr_dat) begin
							shf_r <= tx_buf_r;
							out_bit_r <= first_bit;
							txe_r <= 1'b1;
							ss_r <= 1'b0;
							edg_r <= 5'd0;
							st_r <= LEAD;
						end else if (!master && s_start) begin
							shf_r <= tx_buf_r;
							out_bit_r <= first_bit;
							if (!txe_r && !wr_dat)
								txe_r <= 1'b1;
							edg_r <= 5'd0;
							st_r <= RUN;
						end
					end
					LEAD: if (half_tick)
						st_r <= RUN;
					RUN: if (master ? half_tick : (s_edge && s_sel)) begin
						if (master)
							sck_r <= !sck_r;
						edg_r <= 5'(edg_r + 5'd1);
						if (master ? (clock_phase == sck_r) : sample_edge)
							shf_r <= sh_in;
						else if (clock_phase ? edg_r != 5'd0 : 1'b1)
							out_bit_r <= next_bit;
						if (clock_phase && edg_r == 5'd0)
							out_bit_r <= lsb ? shf_r[0] : shf_r[7];
						if (edg_r == 5'd15)
							st_r <= TAIL;
					end
					TAIL: if (master ? half_tick : 1'b1) begin
						rx_buf_r <= shf_r;
						rxf_r <= 1'b1;
						ss_r <= 1'b1;
						st_r <= IDLE;
					end
					default: st_r <= IDLE;
				endcase
				if (!master && st_r != IDLE && f_ss_r && !clock_phase)
					st_r <= IDLE;
			end
		end
	end

	// ==========================================================
	// pins
	wire drive_m = en && master;
	wire drive_s = en && !master && s_sel;
	assign pins_out.sck  = sck_r ^ clock_polarity;
	assign pins_out.mosi = out_bit_r;
	assign pins_out.ss_n = ss_r;
	assign pins_oe.sck_oe_n  = !drive_m;
	assign pins_oe.mosi_oe_n = !(bidir ? (drive_m && ctrl2_r[B_BOE]) : drive_m);
	assign pins_oe.miso_oe_n = !(bidir ? (drive_s && ctrl2_r[B_BOE]) : drive_s);
	assign pins_oe.ss_oe_n   = !(en && ss_drive);
	assign irq = (ctrl1_r[B_IRQ] && (rxf_r || mode_fault_flag_r)) || (ctrl1_r[B_TIE] && txe_r);
endmodule : spi_cfg

// ### spi_cfg_pkg.sv
// Purpose: constants and carrier types for the serial peripheral block
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: offsets and reset values are local choices
package spi_cfg_pkg;
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_RATE  = 8'h08;
	localparam logic [7:0] OFS_FLAGS = 8'h0c;
	localparam logic [7:0] OFS_DATA  = 8'h10;
	localparam logic [7:0] CTRL1_RST = 8'h04;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] RATE_RST  = 8'h00;
	localparam logic [7:0] CTRL1_MSK = 8'hff;
	localparam logic [7:0] CTRL2_MSK = 8'h1b;
	localparam logic [7:0] RATE_MSK  = 8'h77;
	localparam int B_IRQ = 7, B_EN = 6, B_TIE = 5, B_MST = 4;
	localparam int B_POL = 3, B_PHA = 2, B_SELECT_OUTPUT_ENABLE = 1, B_LSB = 0;
	localparam int B_FEN = 4, B_BOE = 3, B_SWAI = 1, B_SINGLE_WIRE_SELECT = 0;
	localparam int B_RXF = 7, B_TXE = 5, B_MODE_FAULT_FLAG = 4;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic sck;
		logic mosi;
		logic ss_n;
	} pins_out_t;

	typedef struct packed {
		logic sck_oe_n;
		logic mosi_oe_n;
		logic miso_oe_n;
		logic ss_oe_n;
	} pins_oe_t;
endpackage : spi_cfg_pkg

// ### spi_cfg_properties.sv
// Purpose: port-level checks for spi_cfg
// Assumes: the bench offers write address and data together
// Notes: register shadows may lead the design by a cycle, hence repeats
`timescale 1ns/100ps
module spi_cfg_properties (
	input wire logic                   sys_clk,
	input wire logic                   rst,
	input wire logic [7:0]             s_axi_awaddr,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic [31:0]            s_axi_wdata,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic                   s_axi_bvalid,
	input wire logic [7:0]             s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic [1:0]             s_axi_rresp,
	input wire logic                   s_axi_rvalid,
	input wire logic                   ss_n_in,
	input wire spi_cfg_pkg::pins_oe_t  pins_oe,
	input wire logic                   irq
);
	import spi_cfg_pkg::*;
	// ==========
	// register shadows
	logic [7:0] c1_r, c2_r, ra_r;
	wire        wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire        mapped = ra_r <= OFS_DATA && ra_r[1:0] == 2'b00;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			c1_r <= CTRL1_RST;
			c2_r <= CTRL2_RST;
		end else if (wr_go && s_axi_awaddr == OFS_CTRL1) begin
			c1_r <= s_axi_wdata[7:0];
		end else if (wr_go && s_axi_awaddr == OFS_CTRL2) begin
			c2_r <= s_axi_wdata[7:0];
		end
	end
	always_ff @(posedge sys_clk) begin
		if (s_axi_arvalid && s_axi_arready) begin
			ra_r <= s_axi_araddr;
		end
	end
	// ==========
	// properties
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence wr_taken;
		wr_go;
	endsequence
	sequence fault_seen;
		(c1_r[B_EN] && c1_r[B_MST] && c2_r[B_FEN] && !c1_r[B_SELECT_OUTPUT_ENABLE] && !ss_n_in) [*3];
	endsequence
	wr_resp_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	rd_decode_a: assert property (s_axi_rvalid |-> s_axi_rresp == (mapped ? RESP_OKAY : RESP_SLVERR))
		else $error("wrong read response");
	irq_masked_a: assert property ((!c1_r[B_IRQ] && !c1_r[B_TIE]) [*3] |-> !irq)
		else $error("irq with masks clear");
	off_drivers_a: assert property (!c1_r[B_EN] [*3] |-> pins_oe == 4'hf)
		else $error("disabled block drives pins");
	slave_sck_a: assert property (!c1_r[B_MST] [*3] |-> pins_oe.sck_oe_n)
		else $error("slave drives clock");
	fault_off_a: assert property (fault_seen |-> ##[0:8] pins_oe.sck_oe_n)
		else $error("fault left clock driven");
endmodule : spi_cfg_properties

bind spi_cfg spi_cfg_properties u_props (.*);

// ### spi_peer.sv
// Purpose: external serial slave facing the block in master mode
// Assumes: clock idles low, data out on rising, sampled on falling edge
// Notes: no pull on the return line, so a released line shows the inverted bit
`timescale 1ns/100ps
module spi_peer (
	input  wire logic  sck,
	input  wire logic  mosi,
	input  wire logic  ss_n,
	output logic       miso,
	output logic [7:0] shift_r
);
	initial begin
		miso    = 1'b0;
		shift_r = 8'ha5;
	end
	always @(posedge sck) if (!ss_n) miso <= shift_r[7];
	always @(negedge sck) if (!ss_n) shift_r <= {shift_r[6:0], mosi};
	always @(posedge ss_n) miso <= ~miso;
endmodule : spi_peer

// ### test_spi_cfg.sv
// Purpose: self-checking bench for spi_cfg
// Assumes: peer answers in clock mode one; select line has a pull-up
// Notes: ss_low pulls the select line down to provoke a mode fault
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fails++; \
	$display("unexpected %0t: got %h want %h", $time, (a), (e)); end end
module test_spi_master_slave_config;
	import spi_cfg_pkg::*;
	logic        sys_clk, rst, wait_mode, ss_low, irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, peer_byte;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        sck_in, mosi_in, miso_in, ss_n_in;
	pins_out_t   pins_out;
	pins_oe_t    pins_oe;
	int          fails, comparisons;
	assign ss_n_in = ss_low ? 1'b0 : (pins_oe.ss_oe_n | pins_out.ss_n);
	assign sck_in  = !pins_oe.sck_oe_n & pins_out.sck;
	assign mosi_in = pins_out.mosi;
	spi_cfg dut (.*);
	spi_peer peer (.sck(sck_in), .mosi(mosi_in), .ss_n(ss_n_in), .miso(miso_in), .shift_r(peer_byte));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// ==========
	// bus tasks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge sys_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do begin
			@(negedge sys_clk);
			ta = s_axi_awready;
			tw = s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge sys_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
		logic ta, tv;
		@(posedge sys_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do begin
			@(negedge sys_clk);
			ta = s_axi_arready;
			tv = s_axi_rvalid;
			d  = s_axi_rdata[7:0];
			r  = s_axi_rresp;
			@(posedge sys_clk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tv);
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic [1:0] r;
		rd(a, d, r);
		`CHK({r, d}, {RESP_OKAY, e})
	endtask : chk_rd
	// ==========
	// scenarios
	task automatic t_regs;
		logic [7:0] d;
		logic [1:0] r;
		chk_rd(OFS_CTRL1, CTRL1_RST);
		chk_rd(OFS_FLAGS, 8'h20);
		wr(OFS_CTRL2, 8'hff);
		wr(OFS_RATE, 8'hff);
		wr(OFS_FLAGS, 8'hff);
		chk_rd(OFS_CTRL2, CTRL2_MSK);
		chk_rd(OFS_RATE, RATE_MSK);
		chk_rd(OFS_FLAGS, 8'h20);
		rd(8'h14, d, r);
		`CHK({r, d}, {RESP_SLVERR, 8'h00})
		wr(OFS_CTRL2, 8'h00);
	endtask : t_regs
	task automatic t_irq;
		wr(OFS_CTRL1, 8'h60);
		@(negedge sys_clk);
		`CHK(irq, 1'b1)
		wr(OFS_CTRL1, 8'h40);
		@(negedge sys_clk);
		`CHK(irq, 1'b0)
	endtask : t_irq
	task automatic t_xfer(input logic [7:0] c1, rt, tx, rx, pb, input int half, input bit full);
		logic [7:0] d;
		logic [1:0] r;
		time        t0;
		wr(OFS_CTRL1, c1);
		wr(OFS_CTRL2, 8'h10);
		wr(OFS_RATE, rt);
		wr(OFS_DATA, tx);
		@(posedge pins_out.sck) t0 = $time;
		@(posedge pins_out.sck) `CHK($time - t0, half * 200)
		`CHK(pins_oe.sck_oe_n, 1'b0)
		repeat (400) begin
			rd(OFS_FLAGS, d, r);
			if (d[B_RXF]) break;
		end
		`CHK(d[B_RXF], 1'b1)
		`CHK(irq, c1[B_IRQ])
		`CHK(pins_out.sck, 1'b0)
		rd(OFS_DATA, d, r);
		if (full) `CHK({d, peer_byte}, {rx, pb})
	endtask : t_xfer
	task automatic t_fault;
		wr(OFS_CTRL1, 8'h50);
		wr(OFS_CTRL2, 8'h00);
		ss_low <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk_rd(OFS_CTRL1, 8'h50);
		wr(OFS_CTRL2, 8'h10);
		repeat (8) @(posedge sys_clk);
		chk_rd(OFS_CTRL1, 8'h40);
		`CHK(pins_oe.sck_oe_n, 1'b1)
		ss_low <= 1'b0;
		wr(OFS_CTRL1, 8'h40);
		chk_rd(OFS_FLAGS, 8'h30);
		wr(OFS_CTRL1, 8'h40);
		chk_rd(OFS_FLAGS, 8'h20);
	endtask : t_fault
	task automatic results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, wait_mode, ss_low} = '0;
		s_axi_wstrb = 4'hf;
		rst         = 1'b1;
		fails       = 0;
		comparisons = 0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_irq();
		t_xfer(8'hd6, 8'h12, 8'h1e, 8'ha5, 8'h1e, 8, 1'b1);
		t_xfer(8'h57, 8'h12, 8'h1e, 8'h78, 8'h78, 8, 1'b1);
		t_xfer(8'h56, 8'h00, 8'h00, 8'h00, 8'h00, 1, 1'b0);
		t_fault();
		results();
	end
	initial begin
		#2_000_000;
		fails++;
		results();
	end
endmodule : test_spi_master_slave_config
